// file: dv/rft_plant.sv
// output stage model: sensed output voltage and soft-start for the supervisor
`timescale 1ns/1ps
`default_nettype none

module rft_plant (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // drive and command from the supervisor
  input  wire logic       high_side_drive,
  input  wire logic [9:0] vout_cmd,
  // bench knob: output level in percent of the command
  input  wire logic [6:0] pct,
  // sensed side
  output logic      [9:0] vout_sense,
  output logic            soft_start_done
);
  logic [3:0] ss_cnt_ff;

  // no output filter, so a knob step shows on the sense input at once
  assign vout_sense = 10'((17'(vout_cmd) * 17'(pct)) / 17'h00064);

  // soft-start restarts on every drop of the high side, as after a hiccup
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      ss_cnt_ff <= 4'h0;
    else if (!high_side_drive)
      ss_cnt_ff <= 4'h0;
    else if (ss_cnt_ff != 4'h8)
      ss_cnt_ff <= ss_cnt_ff + 4'h1;

  assign soft_start_done = (ss_cnt_ff == 4'h8);
endmodule

`default_nettype wire

// file: dv/rft_supervisor_bench.sv
// self-checking bench for the regulator supervisor
`timescale 1ns/1ps
`default_nettype none

module rft_supervisor_bench;
  localparam int unsigned ARM_N = 20;
  localparam int unsigned HIC_N = 30;
  localparam logic [7:0]  BCODE [8] = '{8'hA1, 8'hB7, 8'hE5, 8'hEF, 8'hF0, 8'hF7, 8'hFD, 8'hFF};
  localparam logic [9:0]  BCMD  [8] = '{10'h0D6, 10'h0F5, 10'h218, 10'h27C, 10'h27D, 10'h284,
                                        10'h2BF, 10'h000};
  // offset code, thermistor ratio, current at 100 lsb raw, temperature
  localparam logic [27:0] TROW  [5] = '{{2'h0, 8'hD8, 10'h06F, 8'h19},
                                        {2'h1, 8'hD8, 10'h069, 8'h19},
                                        {2'h2, 8'hD8, 10'h065, 8'h19},
                                        {2'h3, 8'hD8, 10'h064, 8'h19},
                                        {2'h3, 8'h80, 10'h079, 8'h50}};
  logic        mclk, pready, pslverr, hs, ls, pok, irq, ssd;
  logic        rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        cfg3 = 1'b0, en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, seed = 32'h61561C8A;
  logic [31:0] prdata;
  logic [7:0]  boot = 8'hE5, therm = 8'hD8;
  logic [7:0]  temp_t;
  logic [1:0]  cfg2 = 2'h3;
  logic [3:0]  rail = 4'h0;
  logic [9:0]  isense = 10'h000;
  logic [9:0]  vsense, vcmd, iout;
  logic [6:0]  pct = 7'h64;
  logic [32:0] exp_q [$];
  int          errors = 0, checks = 0, n;

  rft_supervisor #(.ARM_CYCLES(ARM_N), .HICCUP_CYCLES(HIC_N)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_level_select_pin(boot), .second_config_pin(cfg2), .third_config_pin(cfg3),
    .enable_pin(en), .rail_ok(rail), .thermistor_input(therm), .vout_sense(vsense),
    .isense_raw(isense), .soft_start_done(ssd), .high_side_drive(hs), .low_side_drive(ls),
    .power_ok_output(pok), .vout_cmd(vcmd), .iout_telemetry(iout),
    .temp_telemetry(temp_t), .irq(irq));

  rft_plant plant_u (.mclk(mclk), .rst_n(rst_n), .high_side_drive(hs), .vout_cmd(vcmd),
    .pct(pct), .vout_sense(vsense), .soft_start_done(ssd));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction

  task automatic stop_test();
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one transfer; a read notes {pslverr, prdata} for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e = 33'h0);
    int k;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    if (!w)
      exp_q.push_back(e);
    k = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge mclk);
      k++;
    end
    chk("pready", 33'(pready), 33'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge mclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk("prdata", {pslverr, prdata}, exp_q.pop_front());

  // read the event register, then clear it
  task automatic ev(input logic [31:0] e);
    apb(1'b0, rft_pkg::OFS_ISTAT, 32'h0, {1'b0, e});
    apb(1'b1, rft_pkg::OFS_ISTAT, 32'h1F);
  endtask

  // let c edges pass, then settle at the falling edge
  task automatic at(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic wait_hs(input logic v);
    n = 0;
    while (hs !== v && n < 200)
    begin
      @(posedge mclk);
      n++;
    end
    chk("high_side_drive", 33'(hs), 33'(v));
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, rft_pkg::OFS_CTRL, 32'h0, 33'h003);
    apb(1'b0, rft_pkg::OFS_IMASK, 32'h0, 33'h000);
    apb(1'b0, 12'h040, 32'h0, {1'b1, 32'h0});
    apb(1'b1, rft_pkg::OFS_VCMD, 32'h3FF);
    // rails held low so the boot pin is still sampled
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk) boot <= BCODE[i];
      at(3);
      chk("vout_cmd", 33'(vcmd), 33'(BCMD[i]));
    end
    @(posedge mclk) boot <= 8'hE5;
    @(posedge mclk) rail <= 4'hF;
    wait_hs(1'b1);
    at(12);
    chk("power_ok", 33'(pok), 33'h1);
    apb(1'b0, rft_pkg::OFS_VCMD, 32'h0, 33'h218);
    apb(1'b1, rft_pkg::OFS_ISTAT, 32'h1F);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk);
      cfg2   <= TROW[i][27:26];
      therm  <= TROW[i][25:18];
      isense <= 10'h064;
      at(5);
      chk("iout", 33'(iout), 33'(TROW[i][17:8]));
      chk("temp", 33'(temp_t), 33'(TROW[i][7:0]));
    end
    @(posedge mclk) therm <= 8'hD8;
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      @(posedge mclk) isense <= 10'(seed % 32'hBC);
      at(4);
      chk("iout_rand", 33'(iout), 33'(seed % 32'hBC));
    end
    apb(1'b1, rft_pkg::OFS_IMASK, 32'h04);
    @(posedge mclk) cfg2 <= 2'h2;
    isense <= 10'h0B8;
    at(4);
    chk("below_limit", 33'(hs), 33'h1);
    @(posedge mclk) isense <= 10'h0B9;
    wait_hs(1'b0);
    at(1);
    chk("power_ok", 33'(pok), 33'h0);
    chk("low_side", 33'(ls), 33'h0);
    chk("irq_ocp", 33'(irq), 33'h1);
    apb(1'b0, rft_pkg::OFS_STAT, 32'h0, 33'h322);
    @(posedge mclk) isense <= 10'h000;
    at(5);
    chk("latched", 33'(hs), 33'h0);
    @(posedge mclk) rail <= 4'hE;
    at(3);
    @(posedge mclk) rail <= 4'hF;
    wait_hs(1'b1);
    ev(32'h14);
    // retry by pin, then by the software response bit
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, rft_pkg::OFS_CTRL, (i == 0) ? 32'h03 : 32'h1B);
      @(posedge mclk) cfg3 <= (i == 0);
      isense <= 10'h0B9;
      wait_hs(1'b0);
      isense <= 10'h000;
      wait_hs(1'b1);
      chk("hiccup", 33'(n >= HIC_N - 1 && n <= HIC_N + 3), 33'h1);
    end
    apb(1'b1, rft_pkg::OFS_CTRL, 32'h03);
    cfg3 <= 1'b0;
    apb(1'b1, rft_pkg::OFS_ISTAT, 32'h1F);
    apb(1'b1, rft_pkg::OFS_IMASK, 32'h08);
    @(posedge mclk) therm <= 8'h3A;
    at(4);
    chk("cool_side", 33'(hs), 33'h1);
    @(posedge mclk) therm <= 8'h39;
    wait_hs(1'b0);
    at(2);
    chk("power_ok", 33'(pok), 33'h0);
    chk("irq", 33'(irq), 33'h1);
    @(posedge mclk) therm <= 8'h48;
    at(6);
    chk("hysteresis", 33'(hs), 33'h0);
    @(posedge mclk) therm <= 8'h50;
    wait_hs(1'b1);
    therm <= 8'hD8;
    ev(32'h08);
    at(1);
    chk("irq", 33'(irq), 33'h0);
    apb(1'b1, rft_pkg::OFS_IMASK, 32'h00);
    @(posedge mclk) pct <= 7'h74;
    at(4);
    chk("ovp_edge", 33'(hs), 33'h1);
    @(posedge mclk) pct <= 7'h75;
    wait_hs(1'b0);
    at(2);
    chk("discharge", 33'(ls), 33'h1);
    chk("irq_masked", 33'(irq), 33'h0);
    @(posedge mclk) pct <= 7'h63;
    at(4);
    chk("discharge", 33'(ls), 33'h0);
    chk("latched", 33'(hs), 33'h0);
    @(posedge mclk) pct <= 7'h75;
    at(4);
    chk("discharge", 33'(ls), 33'h1);
    // enable falls while the output is still high: the fresh fault must win
    @(posedge mclk) en <= 1'b0;
    at(3);
    chk("set_wins", 33'(ls), 33'h1);
    @(posedge mclk) pct <= 7'h64;
    en <= 1'b1;
    at(3);
    chk("latched", 33'(hs), 33'h0);
    @(posedge mclk) en <= 1'b0;
    at(3);
    @(posedge mclk) en <= 1'b1;
    wait_hs(1'b1);
    ev(32'h01);
    at(12);
    @(posedge mclk) pct <= 7'h4B;
    at(4);
    chk("uvp_edge", 33'(hs), 33'h1);
    @(posedge mclk) pct <= 7'h49;
    wait_hs(1'b0);
    at(1);
    chk("low_side", 33'(ls), 33'h0);
    @(posedge mclk) pct <= 7'h64;
    apb(1'b1, rft_pkg::OFS_CTRL, 32'h02);
    apb(1'b1, rft_pkg::OFS_CTRL, 32'h03);
    at(5);
    chk("no_cmd_clear", 33'(hs), 33'h0);
    apb(1'b1, rft_pkg::OFS_CTRL, 32'h07);
    apb(1'b1, rft_pkg::OFS_CTRL, 32'h06);
    apb(1'b1, rft_pkg::OFS_CTRL, 32'h07);
    wait_hs(1'b1);
    ev(32'h02);
    @(posedge mclk) rail <= 4'hB;
    wait_hs(1'b0);
    at(1);
    chk("power_ok", 33'(pok), 33'h0);
    @(posedge mclk) rail <= 4'hF;
    wait_hs(1'b1);
    ev(32'h10);
    at(12);
    chk("power_ok", 33'(pok), 33'h1);
    stop_test();
  end
endmodule

`default_nettype wire

// file: hw/rft_supervisor.sv
// fault manager, boot decode and current trim with an apb register file
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RULE1] command word steps 7.8125 mV per lsb; neighbours may jump several steps
// [RULE2] second config pin picks offset: 0=+30, 1=+15, 2=+5, 3=off
// [RULE3] offset plus thermistor temperature gives the current gain adjustment
// [RULE4] compensated current drives both telemetry and overcurrent check
// [RULE5] integrator should pick the +5 degree offset
// [RULE6] thermistor ratio to bias becomes a temperature-linear code, nonlinear map
// [RULE7] lockout and over-temperature follow the condition with hysteresis, no latch
// [RULE8] any rail lockout stops regulation until that rail recovers
// [RULE9] above 116 percent latch off; low-side discharge until below 100 percent
// [RULE10] below 74 percent latch off
// [RULE11] compensated current at 18.8 A declares overcurrent
// [RULE12] overcurrent latches or retries, by third config pin or fault response bit
// [RULE13] retry waits 9 ms before each restart while fault persists
// [RULE14] latches clear by bias cycle, enable toggle or operation command
// [RULE15] shut down above 136 degrees, resume below 122; the code shuts down at 136 already
// [RULE16] power ok low on lockout, overcurrent, over/undervoltage or overtemperature
// [RULE17] startup overvoltage armed 5.5 ms after rails good until soft-start ends
// [RULE18] fixed 8-bit to 10-bit boot lookup; all-ones gives zero
// [RULE19] both gate enables low during faults, except overvoltage discharge
module rft_supervisor #(
  parameter int unsigned ARM_CYCLES    = rft_pkg::ARM_CYC,
  parameter int unsigned HICCUP_CYCLES = rft_pkg::HICCUP_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // configuration pins
  input  wire logic [7:0]  boot_level_select_pin,
  input  wire logic [1:0]  second_config_pin,
  input  wire logic        third_config_pin,
  input  wire logic        enable_pin,
  // analog front end
  input  wire logic [3:0]  rail_ok,
  input  wire logic [7:0]  thermistor_input,
  input  wire logic [9:0]  vout_sense,
  input  wire logic [9:0]  isense_raw,
  input  wire logic        soft_start_done,
  // drive and status
  output logic             high_side_drive,
  output logic             low_side_drive,
  output logic             power_ok_output,
  output logic [9:0]       vout_cmd,
  output logic [9:0]       iout_telemetry,
  output logic [7:0]       temp_telemetry,
  output logic             irq
);
  if (HICCUP_CYCLES == 0 || HICCUP_CYCLES >= (1 << rft_pkg::CNT_W) ||
      ARM_CYCLES == 0 || ARM_CYCLES >= (1 << rft_pkg::CNT_W))
    $error("cycle counts do not fit the counters");

  typedef struct packed {
    rft_pkg::rft_state_t st;
    logic [4:0]          ctrl;
    logic [4:0]          istat;
    logic [4:0]          imask;
    logic                ovp_l;
    logic                uvp_l;
    logic                ocp_l;
    logic                otp_h;
    logic                ld;
    logic                en_prev;
    logic                op_prev;
    logic                bias_prev;
    logic                supply_lockout_prev;
    logic [21:0]         arm_cnt;
    logic                armed;
    logic [21:0]         hic_cnt;
    logic [9:0]          vcmd;
    logic [9:0]          iout;
    logic [7:0]          temp;
    logic [31:0]         rdata;
    logic                slverr;
  } rft_regs_t;

  rft_regs_t r_ff;
  rft_regs_t nxt_r;

  // percent scaling shared by all voltage comparisons
  function automatic logic [17:0] pct(input logic [9:0] v, input logic [6:0] p);
    pct = 18'(v) * 18'(p);
  endfunction

  logic        [7:0]  temp_w;
  logic        [7:0]  ofs_w;
  logic signed [10:0] eff_w;
  logic signed [12:0] gain_s;
  logic        [21:0] prod_w;
  logic        [9:0]  comp_w;
  logic        [9:0]  boot_cmd_w;
  logic               supply_lockout_w;
  logic               retry_w;
  logic               on_req_w;
  logic               clear_w;
  logic               ovp_en_w;
  logic               ovp_set_w;
  logic               uvp_set_w;
  logic               ocp_w;
  logic               latched_n;
  logic               wr_w;
  logic               rd_setup_w;

  assign temp_w     = rft_pkg::ntc_to_temp(thermistor_input); // RULE6
  assign boot_cmd_w = rft_pkg::boot_to_cmd(boot_level_select_pin); // RULE18 RULE1
  assign supply_lockout_w     = rail_ok != rft_pkg::RAILS_OK;
  assign retry_w    = r_ff.ctrl[rft_pkg::CTRL_SW_RESP] ? r_ff.ctrl[rft_pkg::CTRL_RETRY]
                                                       : third_config_pin; // RULE12
  assign on_req_w   = (enable_pin | ~r_ff.ctrl[rft_pkg::CTRL_USE_PIN]) &
                      (r_ff.ctrl[rft_pkg::CTRL_OP] | ~r_ff.ctrl[rft_pkg::CTRL_USE_CMD]);
  assign wr_w       = psel & penable & pwrite;
  assign rd_setup_w = psel & ~penable;

  always_comb
  begin
    case (second_config_pin) // RULE2
      2'h0:    ofs_w = rft_pkg::OFS_30;
      2'h1:    ofs_w = rft_pkg::OFS_15;
      2'h2:    ofs_w = rft_pkg::OFS_5;
      default: ofs_w = 8'h00;
    endcase
    // gain of about 0.39 percent per degree about the reference
    eff_w  = $signed({3'h0, temp_w}) + $signed({3'h0, ofs_w})
           - $signed({3'h0, rft_pkg::TEMP_REF}); // RULE3
    gain_s = rft_pkg::GAIN_ONE + (13'(eff_w) <<< rft_pkg::GAIN_SHIFT);
    prod_w = 22'(isense_raw) * 22'(gain_s[11:0]);
    comp_w = (|prod_w[21:20]) ? 10'h3FF : prod_w[19:10];
  end

  // startup check before soft-start ends, normal check once running
  assign ovp_en_w  = (r_ff.armed & ~soft_start_done) |
                     (r_ff.st == rft_pkg::ST_RUN & soft_start_done); // RULE17
  assign ovp_set_w = ovp_en_w &
                     pct(vout_sense, rft_pkg::PCT_FULL) > pct(r_ff.vcmd, rft_pkg::PCT_OVP);
  assign uvp_set_w = r_ff.st == rft_pkg::ST_RUN & soft_start_done &
                     pct(vout_sense, rft_pkg::PCT_FULL) < pct(r_ff.vcmd, rft_pkg::PCT_UVP);
  assign ocp_w     = r_ff.st == rft_pkg::ST_RUN & comp_w >= rft_pkg::OCP_LIMIT; // RULE11
  assign clear_w   = (rail_ok[0] & ~r_ff.bias_prev) |
                     (r_ff.ctrl[rft_pkg::CTRL_USE_PIN] & r_ff.en_prev & ~enable_pin) |
                     (r_ff.ctrl[rft_pkg::CTRL_USE_CMD] & r_ff.op_prev &
                      ~r_ff.ctrl[rft_pkg::CTRL_OP]); // RULE14
  assign latched_n = nxt_r.ovp_l | nxt_r.uvp_l | nxt_r.ocp_l;

  always_comb
  begin
    logic [4:0] ev;
    logic       hold;
    nxt_r = r_ff;
    ev    = 5'h00;
    hold  = supply_lockout_w | r_ff.otp_h;
    nxt_r.en_prev   = enable_pin;
    nxt_r.op_prev   = r_ff.ctrl[rft_pkg::CTRL_OP];
    nxt_r.bias_prev = rail_ok[0];
    nxt_r.supply_lockout_prev = supply_lockout_w;
    nxt_r.iout      = comp_w; // RULE4
    nxt_r.temp      = temp_w;
    // rails must stay good for the whole arming delay
    if (supply_lockout_w)
    begin
      nxt_r.arm_cnt = 22'h000000;
      nxt_r.armed   = 1'b0;
    end
    else if (!r_ff.armed)
    begin
      nxt_r.arm_cnt = r_ff.arm_cnt + 22'h000001;
      nxt_r.armed   = r_ff.arm_cnt == 22'(ARM_CYCLES - 1); // RULE17
    end
    if (!r_ff.armed)
      nxt_r.vcmd = boot_cmd_w; // RULE18
    // hysteretic over-temperature
    if (temp_w >= rft_pkg::OTP_SET)
      nxt_r.otp_h = 1'b1; // RULE15 RULE7
    else if (temp_w < rft_pkg::OTP_CLR)
      nxt_r.otp_h = 1'b0; // RULE15 RULE7
    // set wins over clear on every latch
    nxt_r.ovp_l = (r_ff.ovp_l & ~clear_w) | ovp_set_w; // RULE9
    nxt_r.uvp_l = (r_ff.uvp_l & ~clear_w) | uvp_set_w; // RULE10
    nxt_r.ocp_l = (r_ff.ocp_l & ~clear_w) | (ocp_w & ~retry_w); // RULE12
    if (pct(vout_sense, rft_pkg::PCT_FULL) > pct(r_ff.vcmd, rft_pkg::PCT_OVP))
      nxt_r.ld = 1'b1; // RULE9
    else if (pct(vout_sense, rft_pkg::PCT_FULL) < pct(r_ff.vcmd, rft_pkg::PCT_FULL))
      nxt_r.ld = 1'b0; // RULE9
    if (!nxt_r.ovp_l)
      nxt_r.ld = 1'b0;
    case (r_ff.st)
      rft_pkg::ST_OFF:
        if (latched_n)
          nxt_r.st = rft_pkg::ST_LATCH;
        else if (on_req_w && !hold)
          nxt_r.st = rft_pkg::ST_RUN; // RULE7 RULE8
      rft_pkg::ST_RUN:
        if (latched_n)
          nxt_r.st = rft_pkg::ST_LATCH; // RULE19
        else if (ocp_w)
        begin
          nxt_r.st      = rft_pkg::ST_HICCUP; // RULE13
          nxt_r.hic_cnt = 22'h000000;
        end
        else if (!on_req_w || hold)
          nxt_r.st = rft_pkg::ST_OFF; // RULE8 RULE15
      rft_pkg::ST_HICCUP:
        if (latched_n)
          nxt_r.st = rft_pkg::ST_LATCH;
        else if (r_ff.hic_cnt == 22'(HICCUP_CYCLES - 1))
          nxt_r.st = rft_pkg::ST_OFF; // RULE13
        else
          nxt_r.hic_cnt = r_ff.hic_cnt + 22'h000001;
      rft_pkg::ST_LATCH:
        if (!latched_n)
          nxt_r.st = rft_pkg::ST_OFF; // RULE14
      default:
        nxt_r.st = rft_pkg::ST_OFF;
    endcase
    ev[rft_pkg::FLT_OVP]  = ovp_set_w & ~r_ff.ovp_l;
    ev[rft_pkg::FLT_UVP]  = uvp_set_w & ~r_ff.uvp_l;
    ev[rft_pkg::FLT_OCP]  = ocp_w;
    ev[rft_pkg::FLT_OTP]  = nxt_r.otp_h & ~r_ff.otp_h;
    ev[rft_pkg::FLT_SUPPLY_LOCKOUT] = supply_lockout_w & ~r_ff.supply_lockout_prev;
    // apb: decode in setup, act in access
    if (rd_setup_w)
    begin
      nxt_r.slverr = 1'b0;
      case (paddr)
        rft_pkg::OFS_CTRL:  nxt_r.rdata = 32'(r_ff.ctrl);
        rft_pkg::OFS_STAT:  nxt_r.rdata = {22'h000000, r_ff.st, supply_lockout_w, r_ff.otp_h,
                                           r_ff.ocp_l, r_ff.uvp_l, r_ff.ovp_l,
                                           r_ff.ld, r_ff.armed, r_ff.st == rft_pkg::ST_HICCUP};
        rft_pkg::OFS_ISTAT: nxt_r.rdata = 32'(r_ff.istat);
        rft_pkg::OFS_IMASK: nxt_r.rdata = 32'(r_ff.imask);
        rft_pkg::OFS_VCMD:  nxt_r.rdata = 32'(r_ff.vcmd);
        rft_pkg::OFS_TELEM: nxt_r.rdata = {14'h0000, r_ff.temp, r_ff.iout};
        default:
        begin
          nxt_r.rdata  = 32'h00000000;
          nxt_r.slverr = 1'b1;
        end
      endcase
    end
    nxt_r.istat = r_ff.istat;
    if (wr_w && paddr == rft_pkg::OFS_CTRL)
      nxt_r.ctrl = pwdata[rft_pkg::CTRL_W-1:0];
    if (wr_w && paddr == rft_pkg::OFS_IMASK)
      nxt_r.imask = pwdata[rft_pkg::FLT_W-1:0];
    if (wr_w && paddr == rft_pkg::OFS_ISTAT)
      nxt_r.istat = r_ff.istat & ~pwdata[rft_pkg::FLT_W-1:0];
    nxt_r.istat = nxt_r.istat | ev;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_ff      <= '0;
      r_ff.st   <= rft_pkg::ST_OFF;
      r_ff.ctrl <= rft_pkg::CTRL_RST;
    end
    else
      r_ff <= nxt_r;
  end

  assign prdata          = r_ff.rdata;
  assign pslverr         = r_ff.slverr;
  assign pready          = 1'b1;
  assign high_side_drive = r_ff.st == rft_pkg::ST_RUN; // RULE19
  assign low_side_drive  = r_ff.st == rft_pkg::ST_RUN | r_ff.ld; // RULE19 RULE9
  assign power_ok_output = r_ff.st == rft_pkg::ST_RUN & soft_start_done & ~supply_lockout_w &
                           ~r_ff.otp_h; // RULE16
  assign vout_cmd        = r_ff.vcmd;
  assign iout_telemetry  = r_ff.iout;
  assign temp_telemetry  = r_ff.temp;
  assign irq             = |(r_ff.istat & r_ff.imask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_wait_done;
    r_ff.st == rft_pkg::ST_HICCUP && r_ff.hic_cnt == 22'(HICCUP_CYCLES - 1) && !latched_n;
  endsequence

  sequence s_ocp_retry;
    r_ff.st == rft_pkg::ST_RUN && ocp_w && retry_w && !latched_n;
  endsequence

  sequence s_start_ovp;
    r_ff.armed && !soft_start_done &&
    pct(vout_sense, rft_pkg::PCT_FULL) > pct(r_ff.vcmd, rft_pkg::PCT_OVP);
  endsequence

  sequence s_ld_below;
    r_ff.ld && pct(vout_sense, rft_pkg::PCT_FULL) < pct(r_ff.vcmd, rft_pkg::PCT_FULL);
  endsequence

  // rst_n gates the first edge after release, where vout_cmd still holds reset
  chk_boot_decode: assert property (rst_n && !r_ff.armed |=> // RULE18
                                    vout_cmd == $past(boot_cmd_w))
    else $error("boot command not taken from pin");
  chk_comp_path: assert property (rst_n |=> iout_telemetry == $past(comp_w)) // RULE4
    else $error("telemetry lost compensated current");
  chk_ocp_trip: assert property (ocp_w |=> !high_side_drive) // RULE11
    else $error("overcurrent left high side on");
  chk_otp_hyst: assert property (temp_w >= rft_pkg::OTP_SET |=> r_ff.otp_h ##1 // RULE15
                                 !high_side_drive)
    else $error("over-temperature did not stop regulation");
  chk_supply_lockout_stop: assert property (supply_lockout_w |=> !high_side_drive && !power_ok_output) // RULE8
    else $error("lockout left regulation on");
  chk_gate_off: assert property ((r_ff.ovp_l || r_ff.uvp_l || r_ff.ocp_l) // RULE19
                                 |-> !high_side_drive && (low_side_drive == r_ff.ld))
    else $error("gates driven during latched fault");
  chk_ovp_latch: assert property (ovp_set_w && !clear_w |=> // RULE9
                                  r_ff.ovp_l && !power_ok_output)
    else $error("overvoltage not latched");
  chk_uvp_latch: assert property (uvp_set_w && !clear_w |=> // RULE10
                                  r_ff.uvp_l && !power_ok_output)
    else $error("undervoltage not latched");
  chk_pok_fault: assert property (r_ff.ovp_l || r_ff.uvp_l || r_ff.ocp_l || r_ff.otp_h // RULE16
                                  || supply_lockout_w |-> !power_ok_output)
    else $error("power ok high during a fault");
  chk_otp_keep: assert property (r_ff.otp_h && temp_w >= rft_pkg::OTP_CLR |=> r_ff.otp_h) // RULE7
    else $error("over-temperature released early");
  chk_ld_release: assert property (s_ld_below |=> !r_ff.ld) // RULE9
    else $error("discharge held below target");
  chk_start_ovp: assert property (s_start_ovp |=> r_ff.ovp_l) // RULE17
    else $error("startup overvoltage not latched");
  chk_ovp_unarmed: assert property (!r_ff.armed && !soft_start_done |-> !ovp_set_w) // RULE17
    else $error("overvoltage checked before arming");
  chk_hiccup_go: assert property (s_ocp_retry |=> r_ff.st == rft_pkg::ST_HICCUP && // RULE13
                                  r_ff.hic_cnt == 22'h000000)
    else $error("retry did not start the wait");
  chk_clear_set: assert property (ovp_set_w && clear_w |=> r_ff.ovp_l) // RULE14
    else $error("clear beat a fresh overvoltage");
  chk_hiccup_end: assert property (s_wait_done |=> r_ff.st == rft_pkg::ST_OFF) // RULE13
    else $error("retry wait did not end on time");
  chk_irq_out: assert property (r_ff.ocp_l && !$past(r_ff.ocp_l) && // RULE12
                                r_ff.imask[rft_pkg::FLT_OCP] |-> irq)
    else $error("overcurrent event not signalled");
endmodule
`default_nettype wire

// file: pkg/rft_pkg.sv
// constants, lookups and types for the regulator fault and trim logic
package rft_pkg;
  // clock and timing
  localparam int CLK_MHZ        = 250;
  localparam int ARM_TIME_US    = 5500;
  localparam int HICCUP_TIME_US = 9000;
  localparam int ARM_CYC        = ARM_TIME_US * CLK_MHZ;
  localparam int HICCUP_CYC     = HICCUP_TIME_US * CLK_MHZ;
  localparam int CNT_W          = 22;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_STAT  = 12'h004;
  localparam logic [11:0] OFS_ISTAT = 12'h008;
  localparam logic [11:0] OFS_IMASK = 12'h00C;
  localparam logic [11:0] OFS_VCMD  = 12'h010;
  localparam logic [11:0] OFS_TELEM = 12'h014;
  // control bits
  localparam int CTRL_OP      = 0;
  localparam int CTRL_USE_PIN = 1;
  localparam int CTRL_USE_CMD = 2;
  localparam int CTRL_SW_RESP = 3;
  localparam int CTRL_RETRY   = 4;
  localparam int CTRL_W       = 5;
  localparam logic [4:0] CTRL_RST = 5'h03;
  // fault and event bit positions
  localparam int FLT_OVP  = 0;
  localparam int FLT_UVP  = 1;
  localparam int FLT_OCP  = 2;
  localparam int FLT_OTP  = 3;
  localparam int FLT_SUPPLY_LOCKOUT = 4;
  localparam int FLT_W    = 5;
  // thresholds in percent of the command word
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_OVP  = 7'h74;
  localparam logic [6:0] PCT_UVP  = 7'h4A;
  // current scale is 100 mA per lsb
  localparam logic [9:0] OCP_LIMIT = 10'h0BC;
  localparam logic [7:0] OTP_SET   = 8'h88;
  localparam logic [7:0] OTP_CLR   = 8'h7A;
  localparam logic [7:0] TEMP_REF  = 8'h19;
  localparam logic signed [12:0] GAIN_ONE = 13'sh0400;
  localparam int GAIN_SHIFT = 2;
  localparam logic [7:0] OFS_30 = 8'h1E;
  localparam logic [7:0] OFS_15 = 8'h0F;
  localparam logic [7:0] OFS_5  = 8'h05;
  localparam logic [9:0] BOOT_DEFAULT = 10'h000;
  localparam logic [3:0] RAILS_OK = 4'hF;

  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_RUN    = 2'b01,
    ST_HICCUP = 2'b10,
    ST_LATCH  = 2'b11
  } rft_state_t;

  // boot pin code to output command word, one lsb per 7.8125 mV
  function automatic logic [9:0] boot_to_cmd(input logic [7:0] c);
    logic [9:0] d;
    d = {2'h0, c};
    boot_to_cmd = BOOT_DEFAULT;
    if (c >= 8'hA1 && c <= 8'hB6) boot_to_cmd = 10'h0D6 + (d - 10'h0A1);
    if (c >= 8'hB7 && c <= 8'hBE) boot_to_cmd = 10'h0F5 + 10'((d - 10'h0B7) * 10'h00A);
    if (c >= 8'hC1 && c <= 8'hC8) boot_to_cmd = 10'h13C + (d - 10'h0C1);
    if (c >= 8'hC9 && c <= 8'hD1) boot_to_cmd = 10'h14D + 10'((d - 10'h0C9) * 10'h00A);
    if (c >= 8'hD2 && c <= 8'hD8) boot_to_cmd = 10'h1A4 + (d - 10'h0D2);
    if (c >= 8'hD9 && c <= 8'hDE) boot_to_cmd = 10'h1B4 + 10'((d - 10'h0D9) * 10'h00A);
    if (c >= 8'hE1 && c <= 8'hEF) boot_to_cmd = 10'h1F0 + 10'((d - 10'h0E1) * 10'h00A);
    if (c >= 8'hF0 && c <= 8'hF7) boot_to_cmd = 10'h27D + (d - 10'h0F0);
    if (c >= 8'hF8 && c <= 8'hFC) boot_to_cmd = 10'h28E + 10'((d - 10'h0F8) * 10'h00A);
    case (c)
      8'h9F: boot_to_cmd = 10'h180;
      8'hA0: boot_to_cmd = 10'h086;
      8'hBF: boot_to_cmd = 10'h1A6;
      8'hC0: boot_to_cmd = 10'h08D;
      8'hDF: boot_to_cmd = 10'h280;
      8'hE0: boot_to_cmd = 10'h09A;
      8'hFD: boot_to_cmd = 10'h2BF;
      8'hFE: boot_to_cmd = 10'h2C0;
      8'hFF: boot_to_cmd = 10'h000;
      default: ;
    endcase
  endfunction

  // divider ratio (pin over bias, 1/256 lsb) to degrees, piecewise linear
  function automatic logic [7:0] ntc_to_temp(input logic [7:0] r);
    if (r < 8'h47)
      ntc_to_temp = 8'h7A + (8'h47 - r);
    else if (r < 8'h80)
      ntc_to_temp = 8'h7A - 8'(((10'(r) - 10'h047) * 10'h003) >> 2);
    else
      ntc_to_temp = 8'h50 - 8'(((10'(r) - 10'h080) * 10'h005) >> 3);
  endfunction
endpackage
